// ===== logic/mem_addr_gen_pkg.sv
// package: field layout, modes, register map and reset values
package mem_addr_gen_pkg;

  // ****************************************
  // instruction word fields
  // ****************************************
  localparam int FMT_BIT      = 12;  // long format when set
  localparam int SHORT_MD_BIT = 13;  // short format base-use bit
  localparam int OFF_MSB      = 11;
  localparam int ABASE_MSB    = 18;
  localparam int ABASE_LSB    = 14;
  localparam int MODE_MSB     = 13;
  localparam int MODE_LSB     = 10;
  localparam int SCALE_MSB    = 9;
  localparam int SCALE_LSB    = 7;
  localparam int INDEX_MSB    = 4;
  localparam int INDEX_LSB    = 0;

  // long format modes
  localparam logic [3:0] M_BASE      = 4'h4;
  localparam logic [3:0] M_IP_DISP   = 4'h5;
  localparam logic [3:0] M_RSVD      = 4'h6;
  localparam logic [3:0] M_BASE_IDX  = 4'h7;
  localparam logic [3:0] M_DISP      = 4'hC;
  localparam logic [3:0] M_BASE_DISP = 4'hD;
  localparam logic [3:0] M_IDX_DISP  = 4'hE;
  localparam logic [3:0] M_ALL       = 4'hF;

  localparam logic [2:0]  SCALE_MAX = 3'h4;     // x16, above is reserved
  localparam logic [31:0] IP_BIAS   = 32'h0000_0008;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h08;
  localparam logic [7:0] REG_LAST_ADDR = 8'h0C;
  localparam logic [7:0] REG_LAST_INSN = 8'h10;

  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAULT = 1;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;
  localparam logic        CTRL_RST   = 1'h0;
  localparam logic [1:0]  MASK_RST   = 2'h0;

endpackage

// ===== logic/mem_addr_gen.sv
// module: effective-address generator for memory-format instructions
`timescale 1ns/1ps
`default_nettype none
module mem_addr_gen
  import mem_addr_gen_pkg::*;
#(
  parameter int AW = 32
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // request from the instruction decoder
  input  wire logic        req_valid_i,
  input  wire logic [31:0] insn_i,
  input  wire logic [31:0] disp_i,
  input  wire logic [31:0] ip_i,
  output logic             req_ready_o,
  // register file read port
  output logic [4:0]       rf_abase_sel_o,
  output logic [4:0]       rf_index_sel_o,
  input  wire logic [31:0] rf_abase_data_i,
  input  wire logic [31:0] rf_index_data_i,
  // result to bus control / branch logic
  output logic             addr_valid_o,
  output logic [31:0]      addr_o,
  output logic             addr_virtual_o,
  output logic             fault_o,
  output logic             irq_o,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // the decode reads bits above the byte map, so at least 9 are needed
  if (AW < 9) begin : g_aw_check
    $error("address width must reach above the register map");
  end

  // ****************************************
  // request sequencing
  // ****************************************
  typedef enum logic {ST_IDLE, ST_READ} state_t;
  state_t      state_q;
  logic [31:0] insn_q;
  logic [31:0] disp_q;
  logic [31:0] ip_q;
  logic        ctrl_virt_q;

  wire accept = req_valid_i & req_ready_o;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q     <= ST_IDLE;
      req_ready_o <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          req_ready_o <= ~accept;
          if (accept) state_q <= ST_READ;
        end
        ST_READ: begin
          req_ready_o <= 1'b1;
          state_q     <= ST_IDLE;
        end
      endcase
    end
  end

  // the register file answers the registered selectors within the cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      insn_q         <= 32'h0000_0000;
      disp_q         <= 32'h0000_0000;
      ip_q           <= 32'h0000_0000;
      rf_abase_sel_o <= 5'h00;
      rf_index_sel_o <= 5'h00;
    end else if (accept) begin
      insn_q         <= insn_i;
      disp_q         <= disp_i;
      ip_q           <= ip_i;
      rf_abase_sel_o <= insn_i[ABASE_MSB:ABASE_LSB];
      rf_index_sel_o <= insn_i[INDEX_MSB:INDEX_LSB];
    end
  end

  // ****************************************
  // address arithmetic
  // ****************************************
  // every sum is 32 bits wide so carries fall off the top
  wire        is_long  = insn_q[FMT_BIT];
  wire        short_md = insn_q[SHORT_MD_BIT];
  wire [3:0]  mode     = insn_q[MODE_MSB:MODE_LSB];
  wire [2:0]  scale    = insn_q[SCALE_MSB:SCALE_LSB];
  wire [31:0] offset   = {20'h00000, insn_q[OFF_MSB:0]};
  wire [31:0] scaled   = rf_index_data_i << scale;
  wire [31:0] short_a  = short_md ? rf_abase_data_i + offset
                                  : offset;
  wire        bad_scl  = is_long & (scale > SCALE_MAX);
  wire        bad_mode = is_long & (mode == M_RSVD);
  logic [31:0] long_a;

  // mode decode, one sum per mode
  always_comb begin
    unique case (mode)
      M_BASE:      long_a = rf_abase_data_i;
      M_IP_DISP:   long_a = ip_q + disp_q + IP_BIAS;
      M_BASE_IDX:  long_a = rf_abase_data_i + scaled;
      M_DISP:      long_a = disp_q;
      M_BASE_DISP: long_a = rf_abase_data_i + disp_q;
      M_IDX_DISP:  long_a = scaled + disp_q;
      M_ALL:       long_a = rf_abase_data_i + scaled + disp_q;
      default:     long_a = 32'h0000_0000; // reserved or short codes
    endcase
  end

  wire        done_now  = (state_q == ST_READ);
  wire        fault_now = done_now & (bad_scl | bad_mode);
  wire        good_now  = done_now & ~(bad_scl | bad_mode);
  wire [31:0] eff_addr  = is_long ? long_a : short_a;

  // result stage: valid and fault are one-cycle pulses
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      addr_valid_o   <= 1'b0;
      fault_o        <= 1'b0;
      addr_o         <= 32'h0000_0000;
      addr_virtual_o <= 1'b0;
    end else begin
      addr_valid_o <= good_now;
      fault_o      <= fault_now;
      if (good_now) begin
        addr_o         <= eff_addr;
        addr_virtual_o <= ctrl_virt_q;
      end
    end
  end

  // ****************************************
  // axi4-lite register slave
  // ****************************************
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [31:0] insn_log_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire wr_ok   = (awaddr_q == REG_CTRL) | (awaddr_q == REG_IRQ_STAT) |
                 (awaddr_q == REG_IRQ_MASK);
  wire wr_lane = wr_fire & wstrb0_q;
  wire wr_ctrl = wr_lane & (awaddr_q == REG_CTRL);
  wire wr_stat = wr_lane & (awaddr_q == REG_IRQ_STAT);
  wire wr_mask = wr_lane & (awaddr_q == REG_IRQ_MASK);
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_ok = (s_axi_araddr[AW-1:8] == '0) &
               ((ra == REG_CTRL) | (ra == REG_IRQ_STAT) |
                (ra == REG_IRQ_MASK) | (ra == REG_LAST_ADDR) |
                (ra == REG_LAST_INSN));
  wire [31:0] rd_mux =
    (ra == REG_CTRL)      ? {31'h0, ctrl_virt_q}  :
    (ra == REG_IRQ_STAT)  ? {30'h0, irq_stat_q}   :
    (ra == REG_IRQ_MASK)  ? {30'h0, irq_mask_q}   :
    (ra == REG_LAST_ADDR) ? addr_o                :
    (ra == REG_LAST_INSN) ? insn_log_q            : 32'h0000_0000;
  // sticky events: a new event beats a simultaneous write-one clear
  wire [1:0] events = {fault_now, good_now};
  wire [1:0] stat_d = (irq_stat_q & ~(wr_stat ? wdata_q[1:0] : 2'h0))
                      | events;

  // write address and data may arrive in either order
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q      <= (s_axi_awaddr[AW-1:8] == '0) ? s_axi_awaddr[7:0]
                                                      : 8'hFF;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_have_q     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        wdata_q      <= s_axi_wdata;
        wstrb0_q     <= s_axi_wstrb[0];
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_have_q     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // control, interrupt state and last instruction
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_virt_q <= CTRL_RST;
      irq_mask_q  <= MASK_RST;
      irq_stat_q  <= 2'h0;
      irq_o       <= 1'b0;
      insn_log_q  <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_virt_q <= wdata_q[0];
      if (wr_mask) irq_mask_q <= wdata_q[1:0];
      irq_stat_q <= stat_d;
      irq_o      <= |(stat_d & (wr_mask ? wdata_q[1:0] : irq_mask_q));
      if (done_now) insn_log_q <= insn_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_accept;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_answer;
    !req_ready_o ##1 (addr_valid_o || fault_o);
  endsequence

  a_answer_latency: assert property (s_accept |=> s_answer)
    else $error("no answer two cycles after accept");
  a_short_abs: assert property (addr_valid_o && !insn_q[FMT_BIT] &&
    !insn_q[SHORT_MD_BIT] |-> addr_o == {20'h00000, insn_q[OFF_MSB:0]})
    else $error("short absolute address wrong");
  a_short_base: assert property (addr_valid_o && !insn_q[FMT_BIT] &&
    insn_q[SHORT_MD_BIT] |-> addr_o == $past(rf_abase_data_i) +
    {20'h00000, insn_q[OFF_MSB:0]})
    else $error("short base plus offset wrong");
  a_ip_relative: assert property (addr_valid_o && insn_q[FMT_BIT] &&
    insn_q[MODE_MSB:MODE_LSB] == M_IP_DISP |->
    addr_o == ip_q + disp_q + 32'h0000_0008)
    else $error("ip relative address wrong");
  a_index_scale: assert property (addr_valid_o && insn_q[FMT_BIT] &&
    insn_q[MODE_MSB:MODE_LSB] == M_BASE_IDX |->
    addr_o == $past(rf_abase_data_i) +
    ($past(rf_index_data_i) << insn_q[SCALE_MSB:SCALE_LSB]))
    else $error("scaled index address wrong");
  a_disp_only: assert property (addr_valid_o && insn_q[FMT_BIT] &&
    insn_q[MODE_MSB:MODE_LSB] == M_DISP |-> addr_o == disp_q)
    else $error("displacement address wrong");
  a_scale_fault: assert property (state_q == ST_READ && insn_q[FMT_BIT] &&
    insn_q[SCALE_MSB:SCALE_LSB] > 3'h4 |=> fault_o && !addr_valid_o)
    else $error("reserved scale not faulted");
  a_mode_fault: assert property (state_q == ST_READ && insn_q[FMT_BIT] &&
    insn_q[MODE_MSB:MODE_LSB] == 4'h6 |=> fault_o)
    else $error("reserved mode not faulted");
  a_virt_flag: assert property (addr_valid_o |->
    addr_virtual_o == $past(ctrl_virt_q))
    else $error("virtual flag does not follow control");
  a_irq_level: assert property (irq_o == |(irq_stat_q & irq_mask_q))
    else $error("interrupt level mismatch");
  a_event_sticky: assert property (events != 2'h0 |=>
    (irq_stat_q & $past(events)) == $past(events))
    else $error("event lost against a clear");

endmodule
`default_nettype wire

// ===== tb/rf_model.sv
// partner: register file read port with fixed contents per selector
`timescale 1ns/1ps
`default_nettype none
module rf_model (
  // selectors from the address generator
  input  wire logic [4:0] abase_sel_i,
  input  wire logic [4:0] index_sel_i,
  // register contents back to it
  output logic [31:0]     abase_data_o,
  output logic [31:0]     index_data_o
);
  // register 31 sits near the top so that address sums must wrap
  function automatic logic [31:0] contents(input logic [4:0] s);
    return (s == 5'h1F) ? 32'hFFFF_FFF0 : {22'h0, s, 5'h0};
  endfunction

  // combinational read of the registered selectors
  assign abase_data_o = contents(abase_sel_i);
  assign index_data_o = contents(index_sel_i);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// testbench: address rows, register bus, interrupt and reset checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %0t: got %0h exp %0h", $time, g, e); \
  end end
module testbench;
  import mem_addr_gen_pkg::*;
  typedef struct {logic [31:0] ins, d, ea; logic flt;} row_t;
  logic        clk_i, resetn_i, req_valid_i, req_ready_o, addr_valid_o;
  logic        addr_virtual_o, fault_o, irq_o, exp_virt;
  logic [31:0] insn_i, disp_i, ip_i, addr_o, ad, id, awa, ara, wd, rd;
  logic [4:0]  asel, isel;
  logic        awv, awr, wv, wr_, bv, brdy, arv, arr, rv, rrdy;
  logic [1:0]  br, rr;
  logic [3:0]  ws;
  int          n_mismatch, checks_done;
  // ****************************************
  // cases: short, every long mode, scales, faults
  // ****************************************
  row_t rows [18] = '{
    '{32'h0000_CFFF, 32'h0, 32'h0000_0FFF, 1'b0},
    '{32'h0000_E123, 32'h0, 32'h0000_0183, 1'b0},
    '{32'h0007_E020, 32'h0, 32'h0000_0010, 1'b0},
    '{32'h0000_D000, 32'h0, 32'h0000_0060, 1'b0},
    '{32'h0000_1400, 32'hFFFF_FFF0, 32'h0000_3FF8, 1'b0},
    '{32'h0000_DE02, 32'h0, 32'h0000_0460, 1'b0},
    '{32'h0000_3802, 32'h100, 32'h0000_0140, 1'b0},
    '{32'h0000_3882, 32'h100, 32'h0000_0180, 1'b0},
    '{32'h0000_3902, 32'h100, 32'h0000_0200, 1'b0},
    '{32'h0000_3982, 32'h100, 32'h0000_0300, 1'b0},
    '{32'h0000_F000, 32'h8000_0000, 32'h8000_0000, 1'b0},
    '{32'h0007_F400, 32'h20, 32'h0000_0010, 1'b0},
    '{32'h0000_FC82, 32'hFFFF_FF00, 32'hFFFF_FFE0, 1'b0},
    '{32'h0000_1800, 32'h0, 32'hFFFF_FFE0, 1'b1},
    '{32'h0000_DE82, 32'h0, 32'hFFFF_FFE0, 1'b1},
    '{32'h0000_DF02, 32'h0, 32'hFFFF_FFE0, 1'b1},
    '{32'h0000_DF82, 32'h0, 32'hFFFF_FFE0, 1'b1},
    '{32'h0000_D280, 32'h0, 32'hFFFF_FFE0, 1'b1}};

  mem_addr_gen DUT (.clk_i(clk_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid_i), .insn_i(insn_i), .disp_i(disp_i),
    .ip_i(ip_i), .req_ready_o(req_ready_o), .rf_abase_sel_o(asel),
    .rf_index_sel_o(isel), .rf_abase_data_i(ad), .rf_index_data_i(id),
    .addr_valid_o(addr_valid_o), .addr_o(addr_o),
    .addr_virtual_o(addr_virtual_o), .fault_o(fault_o), .irq_o(irq_o),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .s_axi_rdata(rd), .s_axi_rresp(rr));
  rf_model regs (.abase_sel_i(asel), .index_sel_i(isel),
    .abase_data_o(ad), .index_data_o(id));

  // free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // a wait that ran out of its bound ends the run as a failure
  task automatic tmo(input int n);
    if (n >= 50) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // ****************************************
  // bus tasks: outputs sampled at the edge, before it updates them
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge clk_i);
    awv <= 1'b1; awa <= {24'h0, a}; wv <= 1'b1; wd <= d; brdy <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!bv && n < 50);
    brdy <= 1'b0;
    tmo(n);
    `CHK(br, er)
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge clk_i);
    arv <= 1'b1; ara <= {24'h0, a}; rrdy <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 50);
    rrdy <= 1'b0;
    tmo(n);
    `CHK(rd, e)
    `CHK(rr, er)
  endtask

  // one decode request; the answer must come two edges after accept
  task automatic req(input row_t r);
    int n;
    @(posedge clk_i);
    req_valid_i <= 1'b1; insn_i <= r.ins; disp_i <= r.d;
    ip_i <= 32'h0000_4000;
    n = 0;
    do begin @(posedge clk_i); n++; end while (!req_ready_o && n < 50);
    req_valid_i <= 1'b0;
    tmo(n);
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (!(addr_valid_o || fault_o) && n < 50);
    tmo(n);
    `CHK(n, 2)
    `CHK(fault_o, r.flt)
    `CHK(addr_o, r.ea)
    `CHK(addr_virtual_o, exp_virt)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {resetn_i, req_valid_i, awv, wv, arv, brdy, rrdy, exp_virt} = '0;
    {insn_i, disp_i, ip_i, awa, ara, wd} = '0;
    ws = 4'hF;
    n_mismatch = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    `CHK({addr_valid_o, fault_o, irq_o}, 3'h0)
    axi_rd(REG_CTRL, 32'h0, AXI_OKAY);
    axi_rd(REG_IRQ_STAT, 32'h0, AXI_OKAY);
    axi_rd(REG_IRQ_MASK, 32'h0, AXI_OKAY);
    foreach (rows[i]) req(rows[i]);
    // both events seen, mask still closed
    axi_rd(REG_IRQ_STAT, 32'h3, AXI_OKAY);
    `CHK(irq_o, 1'b0)
    axi_wr(REG_IRQ_MASK, 32'h2, AXI_OKAY);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    axi_wr(REG_IRQ_STAT, 32'h2, AXI_OKAY);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    axi_rd(REG_IRQ_STAT, 32'h1, AXI_OKAY);
    // virtual addressing follows the control bit
    axi_wr(REG_CTRL, 32'h1, AXI_OKAY);
    exp_virt = 1'b1;
    req(rows[3]);
    axi_rd(REG_LAST_INSN, 32'h0000_D000, AXI_OKAY);
    // read-only and unmapped places refuse and keep their contents
    axi_wr(REG_LAST_ADDR, 32'h5, AXI_SLVERR);
    axi_wr(8'h40, 32'h1, AXI_SLVERR);
    axi_rd(8'h40, 32'h0, AXI_SLVERR);
    axi_rd(REG_LAST_ADDR, 32'h0000_0060, AXI_OKAY);
    // a write with lane 0 off is answered but stores nothing
    ws <= 4'h0;
    axi_wr(REG_CTRL, 32'h0, AXI_OKAY);
    ws <= 4'hF;
    axi_rd(REG_CTRL, 32'h1, AXI_OKAY);
    // second reset in mid-run clears control, status and mask
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    axi_rd(REG_CTRL, 32'h0, AXI_OKAY);
    axi_rd(REG_IRQ_MASK, 32'h0, AXI_OKAY);
    axi_rd(REG_IRQ_STAT, 32'h0, AXI_OKAY);
    end_sim();
  end

  // overall guard against a hang
  initial begin
    #1ms;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
